// ### rtl/lhc_top.sv
/*
 Limp home controller: emergency open-drain output, side indicator
 blink, pulsed dim light, test pin latch and supply timeout, with an
 AHB-Lite register slave.
 Assumes mode codes and watchdog events arrive on hclk; comparator and
 pin levels are asynchronous and are synchronised here.
*/
`timescale 1ns/100ps

// Behaviour
// - emergency output is active-low open drain
// - activate on failure or serial command
// - battery low keeps output high impedance
// - side indicator blinks 1.25 Hz while active
// - pulsed light 100 Hz, 20% low
// - shared pin is input during init
// - test pin low all init latches development
// - test pull-up enabled only in init
// - development mode held until power off
// - init forces off, fail-safe forces on
// - normal mode serial command switches on
// - init timeout activates the output
// - watchdog failures in normal activate output
// - restart faults and thermal shutdown activate
// - serial activation released by serial command
// - failure release needs restart, service, command
// - long supply undervoltage flags a timeout
// - supply timeout requests fail-safe and activation
// - failure limit two, or one by setting
// - configuration pin sampled only during init
module lhc_top #(
    parameter int INIT_TO_CYC = lhc_pkg::INIT_TO_CYC,
    parameter int UV_TO_CYC = lhc_pkg::UV_TO_CYC,
    parameter int SI_PERIOD_CYC = lhc_pkg::SI_PERIOD_CYC,
    parameter int SI_LOW_CYC = lhc_pkg::SI_LOW_CYC,
    parameter int PL_PERIOD_CYC = lhc_pkg::PL_PERIOD_CYC,
    parameter int PL_LOW_CYC = lhc_pkg::PL_LOW_CYC
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [2:0] sbc_mode,
    input wire lhc_pkg::lhc_evt_t evt,
    input wire lhc_pkg::lhc_pins_t pins,
    output logic emergency_out_n,
    output logic emergency_oe_n,
    output logic side_indicator_out,
    output logic side_indicator_oe_n,
    output logic pulsed_light_out,
    output logic pulsed_light_oe_n,
    output logic test_pullup_en,
    output logic failsafe_req,
    output logic swdev_mode
);

    localparam int TW = lhc_pkg::TW;

    typedef enum logic [1:0] {ST_OFF, ST_SPI, ST_FAIL, ST_ARMED} lhc_st_t;

    lhc_st_t state;
    lhc_st_t next_state;
    lhc_pkg::lhc_pins_t pins_m;
    lhc_pkg::lhc_pins_t pins_s;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic wd_single;
    logic cmd_on_p;
    logic cmd_off_p;
    logic [TW-1:0] init_cnt;
    logic [TW-1:0] uv_cnt;
    logic [TW-1:0] si_cnt;
    logic [TW-1:0] pl_cnt;
    logic init_expired;
    logic uv_to;
    logic cfg_grp12;
    logic test_hi;
    logic sw_done;
    logic in_init_q;
    logic [1:0] wd_cnt;
    logic [1:0] wd_limit;
    logic wd_hit;
    logic restart_seen;
    logic fail_any;
    logic drive;
    logic batt_low;
    logic m_init;
    logic m_normal;

    // ========================================
    // Register read decode
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == lhc_pkg::ADDR_CFG)
        begin
            d[lhc_pkg::CFG_WD1_BIT] = wd_single;
        end
        else if (a == lhc_pkg::ADDR_STAT)
        begin
            d[0] = drive;
            d[1] = (state == ST_SPI);
            d[2] = (state == ST_FAIL) || (state == ST_ARMED);
            d[3] = (state == ST_ARMED);
            d[4] = swdev_mode;
            d[5] = uv_to;
            d[6] = cfg_grp12;
            d[7] = restart_seen;
            d[9:8] = wd_cnt;
        end
        return d;
    endfunction

    // ========================================
    // AHB-Lite slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Capture the address phase; upper address bits must be zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            wr_pend <= hsel && hready && htrans[1] && hwrite
                && (haddr[31:8] == 24'h00_0000);
            wr_addr <= haddr[7:0];
            if (hsel && hready && htrans[1] && !hwrite
                && (haddr[31:8] == 24'h00_0000))
            begin
                hrdata <= reg_read(haddr[7:0]);
            end
            else
            begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // Command strobes live in the write data phase only
    assign cmd_on_p = wr_pend && (wr_addr == lhc_pkg::ADDR_CMD)
        && hwdata[lhc_pkg::CMD_ON_BIT];
    assign cmd_off_p = wr_pend && (wr_addr == lhc_pkg::ADDR_CMD)
        && hwdata[lhc_pkg::CMD_OFF_BIT];

    // Watchdog limit selection
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wd_single <= lhc_pkg::CFG_WD1_RST;
        end
        else if (ce && wr_pend && (wr_addr == lhc_pkg::ADDR_CFG))
        begin
            wd_single <= hwdata[lhc_pkg::CFG_WD1_BIT];
        end
    end

    // ========================================
    // Pin and comparator synchronisers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pins_m <= '0;
            pins_s <= '0;
        end
        else if (ce)
        begin
            pins_m <= pins;
            pins_s <= pins_m;
        end
    end

    assign batt_low = pins_s.battery_low_inhibit;
    assign m_init = (sbc_mode == lhc_pkg::MODE_INIT);
    assign m_normal = (sbc_mode == lhc_pkg::MODE_NORMAL);

    // ========================================
    // Init timeout: saturates so it stays expired until init ends
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            init_cnt <= '0;
        end
        else if (ce)
        begin
            if (!m_init)
            begin
                init_cnt <= '0;
            end
            else if (!init_expired)
            begin
                init_cnt <= init_cnt + 1'b1;
            end
        end
    end

    assign init_expired = (init_cnt == TW'(INIT_TO_CYC));

    // Supply undervoltage timer, restarts on any break in the condition
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            uv_cnt <= '0;
        end
        else if (ce)
        begin
            if (!(pins_s.ctrl_supply_low && pins_s.battery_above_uv))
            begin
                uv_cnt <= '0;
            end
            else if (!uv_to)
            begin
                uv_cnt <= uv_cnt + 1'b1;
            end
        end
    end

    assign uv_to = (uv_cnt == TW'(UV_TO_CYC));

    // Fail-safe request follows the timeout, suppressed by low battery
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            failsafe_req <= 1'b0;
        end
        else if (ce)
        begin
            failsafe_req <= uv_to && !batt_low;
        end
    end

    // ========================================
    // Configuration and test pin latch during init
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_grp12 <= 1'b0;
            test_hi <= 1'b0;
            sw_done <= 1'b0;
            swdev_mode <= 1'b0;
            in_init_q <= 1'b0;
        end
        else if (ce)
        begin
            in_init_q <= m_init;
            if (m_init)
            begin
                cfg_grp12 <= pins_s.cfg_pin;
                test_hi <= test_hi || pins_s.test_pin;
            end
            // Decided once on the first exit; only power-on reset clears it
            if (in_init_q && !m_init && !sw_done)
            begin
                swdev_mode <= !test_hi;
                sw_done <= 1'b1;
            end
        end
    end

    // Pull-up only in init, so an open pin reads high there
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            test_pullup_en <= 1'b0;
        end
        else if (ce)
        begin
            test_pullup_en <= m_init;
        end
    end

    // ========================================
    // Watchdog failure counting in normal mode
    assign wd_limit = (wd_single || cfg_grp12) ? lhc_pkg::WD_LIMIT_SEL
        : lhc_pkg::WD_LIMIT_DEF;
    assign wd_hit = m_normal && evt.wd_fail
        && ((wd_cnt + 2'h1) >= wd_limit);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wd_cnt <= 2'h0;
        end
        else if (ce)
        begin
            if (!m_normal || evt.wd_ok)
            begin
                wd_cnt <= 2'h0;
            end
            else if (evt.wd_fail && (wd_cnt != 2'h3))
            begin
                wd_cnt <= wd_cnt + 2'h1;
            end
        end
    end

    // Restart must be passed before a failure activation can be released
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            restart_seen <= 1'b0;
        end
        else if (ce)
        begin
            if (state == ST_OFF || state == ST_SPI)
            begin
                restart_seen <= 1'b0;
            end
            else if (sbc_mode == lhc_pkg::MODE_RESTART)
            begin
                restart_seen <= 1'b1;
            end
        end
    end

    // ========================================
    // Activation causes
    always_comb
    begin
        fail_any = (m_init && init_expired)
            || wd_hit
            || ((sbc_mode == lhc_pkg::MODE_RESTART)
                && (evt.ro_short_vcc || evt.ro_short_gnd))
            || ((sbc_mode == lhc_pkg::MODE_RESTART) && uv_to)
            || uv_to
            || evt.ctrl_supply_tsd
            || (sbc_mode == lhc_pkg::MODE_FAILSAFE);
    end

    // Next state; stop, sleep, restart and flash change it only through activation causes
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_OFF:
            begin
                if (batt_low)
                begin
                    next_state = ST_OFF;
                end
                else if (fail_any)
                begin
                    next_state = ST_FAIL;
                end
                else if (m_normal && cmd_on_p)
                begin
                    next_state = ST_SPI;
                end
            end
            ST_SPI:
            begin
                if (fail_any)
                begin
                    next_state = ST_FAIL;
                end
                else if (m_normal && cmd_off_p)
                begin
                    next_state = ST_OFF;
                end
            end
            ST_FAIL:
            begin
                if (m_normal && restart_seen && evt.wd_ok && !fail_any)
                begin
                    next_state = ST_ARMED;
                end
            end
            ST_ARMED:
            begin
                if (fail_any)
                begin
                    next_state = ST_FAIL;
                end
                else if (m_normal && cmd_off_p)
                begin
                    next_state = ST_OFF;
                end
            end
        endcase
        // Init holds the output off until its own timeout fires
        if (m_init && !init_expired)
        begin
            next_state = ST_OFF;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ST_OFF;
        end
        else if (ce)
        begin
            state <= next_state;
        end
    end

    // ========================================
    // Pulse timers; they restart on activation so each blink is whole
    assign drive = (state != ST_OFF) && !batt_low;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            si_cnt <= '0;
            pl_cnt <= '0;
        end
        else if (ce)
        begin
            if (!drive || (si_cnt == TW'(SI_PERIOD_CYC - 1)))
            begin
                si_cnt <= '0;
            end
            else
            begin
                si_cnt <= si_cnt + 1'b1;
            end
            if (!drive || (pl_cnt == TW'(PL_PERIOD_CYC - 1)))
            begin
                pl_cnt <= '0;
            end
            else
            begin
                pl_cnt <= pl_cnt + 1'b1;
            end
        end
    end

    // ========================================
    // Open-drain stages: data is always low, enable low pulls the pin
    assign emergency_out_n = 1'b0;
    assign side_indicator_out = 1'b0;
    assign pulsed_light_out = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            emergency_oe_n <= 1'b1;
            side_indicator_oe_n <= 1'b1;
            pulsed_light_oe_n <= 1'b1;
        end
        else if (ce)
        begin
            emergency_oe_n <= !drive;
            side_indicator_oe_n <= !(drive
                && (si_cnt < TW'(SI_LOW_CYC)));
            // Never driven in init, or the test pin would read low
            pulsed_light_oe_n <= !(drive && !m_init
                && (pl_cnt < TW'(PL_LOW_CYC)));
        end
    end

    // ========================================
    // Assertions
    default clocking lhc_cb @(posedge hclk iff ce);
    endclocking
    default disable iff (!hresetn);

    AST_OD_DRIVE: assert property (
        (state != ST_OFF && !batt_low) |=> !emergency_oe_n)
        else $error("emergency output not driven while active");
    AST_BATT_LOW: assert property (
        batt_low |=> emergency_oe_n && side_indicator_oe_n)
        else $error("outputs driven during battery low");
    AST_SI_IDLE: assert property (
        emergency_oe_n |-> side_indicator_oe_n && pulsed_light_oe_n)
        else $error("lamp pulse while emergency output idle");
    AST_SI_START: assert property (
        $fell(emergency_oe_n) |-> !side_indicator_oe_n)
        else $error("side indicator blink does not start low");
    AST_PIN_INIT: assert property (
        m_init |=> pulsed_light_oe_n && test_pullup_en)
        else $error("test pin driven or pull-up off in init");
    AST_PULLUP_OFF: assert property (
        !m_init |=> !test_pullup_en)
        else $error("test pull-up on outside init");
    AST_SWDEV_HOLD: assert property (
        swdev_mode |=> swdev_mode)
        else $error("development mode lost");
    AST_INIT_OFF: assert property (
        (m_init && !init_expired) |=> state == ST_OFF)
        else $error("output on during init");
    AST_FS_ON: assert property (
        (sbc_mode == lhc_pkg::MODE_FAILSAFE && !batt_low)
        |=> state == ST_FAIL)
        else $error("fail-safe mode did not activate output");
    AST_SPI_ON: assert property (
        (state == ST_OFF && m_normal && cmd_on_p && !batt_low)
        |=> state != ST_OFF)
        else $error("serial activation ignored");
    AST_WD_ONE: assert property (
        (state == ST_OFF && wd_limit == 2'h1 && m_normal
        && evt.wd_fail && !batt_low) |=> state == ST_FAIL)
        else $error("first watchdog failure did not activate");
    AST_SPI_HOLD: assert property (
        (state == ST_SPI && !cmd_off_p) |=> state != ST_OFF)
        else $error("serial activation released without command");
    AST_FAIL_HOLD: assert property (
        state == ST_FAIL |=> state != ST_OFF)
        else $error("failure activation released without service");
    AST_UV_FS: assert property (
        (uv_to && !batt_low) |=> failsafe_req ##1 state != ST_OFF)
        else $error("supply timeout without fail-safe");

endmodule

// ### inc/lhc_pkg.sv
/*
 Shared constants and carrier types for the limp home controller.
 Assumes a 10 MHz system clock and mode codes from the chip state machine.
*/
package lhc_pkg;

    // ========================================
    // Clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int INIT_TO_MS = 256;
    localparam int UV_TO_MS = 1024;
    localparam int INIT_TO_CYC = INIT_TO_MS * (CLK_HZ / 1000);
    localparam int UV_TO_CYC = UV_TO_MS * (CLK_HZ / 1000);
    // Side indicator frequency in millihertz, duty in percent low
    localparam int SI_FREQ_MHZ = 1250;
    localparam int SI_DUTY_PCT = 50;
    localparam int SI_PERIOD_CYC = (CLK_HZ / SI_FREQ_MHZ) * 1000;
    localparam int SI_LOW_CYC = SI_PERIOD_CYC / 100 * SI_DUTY_PCT;
    localparam int PL_FREQ_HZ = 100;
    localparam int PL_DUTY_PCT = 20;
    localparam int PL_PERIOD_CYC = CLK_HZ / PL_FREQ_HZ;
    localparam int PL_LOW_CYC = PL_PERIOD_CYC / 100 * PL_DUTY_PCT;
    localparam int TW = 24;

    // ========================================
    // Watchdog failure limits
    localparam logic [1:0] WD_LIMIT_DEF = 2'h2;
    localparam logic [1:0] WD_LIMIT_SEL = 2'h1;

    // ========================================
    // Register map
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam int CMD_ON_BIT = 0;
    localparam int CMD_OFF_BIT = 1;
    localparam int CFG_WD1_BIT = 0;
    localparam logic CFG_WD1_RST = 1'h0;

    // ========================================
    // Chip mode codes
    localparam logic [2:0] MODE_INIT = 3'h0;
    localparam logic [2:0] MODE_RESTART = 3'h1;
    localparam logic [2:0] MODE_FLASH = 3'h2;
    localparam logic [2:0] MODE_NORMAL = 3'h3;
    localparam logic [2:0] MODE_SLEEP = 3'h4;
    localparam logic [2:0] MODE_STOP = 3'h5;
    localparam logic [2:0] MODE_FAILSAFE = 3'h6;

    // ========================================
    // Carriers
    typedef struct packed {
        logic battery_low_inhibit;
        logic ctrl_supply_low;
        logic battery_above_uv;
        logic test_pin;
        logic cfg_pin;
    } lhc_pins_t;

    typedef struct packed {
        logic wd_fail;
        logic wd_ok;
        logic ro_short_vcc;
        logic ro_short_gnd;
        logic ctrl_supply_tsd;
    } lhc_evt_t;

endpackage

// ### verif/lhc_loads.sv
/*
 Lamp loads and pull-ups on the three limp home pins.
 Assumes oe_n low means the device pulls its pin low.
*/
`timescale 1ns/100ps
module lhc_loads (
    input wire logic em_out,
    input wire logic em_oe_n,
    input wire logic si_out,
    input wire logic si_oe_n,
    input wire logic pl_out,
    input wire logic pl_oe_n,
    input wire logic strap_gnd,
    output logic em_pin,
    output logic si_pin,
    output logic pl_pin
);
    // ========================================
    // Pin levels
    // Released pins rise through the load, never float
    assign em_pin = em_oe_n ? 1'b1 : em_out;
    assign si_pin = si_oe_n ? 1'b1 : si_out;
    // A grounded strap holds the shared pin low while released
    assign pl_pin = !pl_oe_n ? pl_out : !strap_gnd;
endmodule

// ### verif/limp_home_controller_test.sv
/*
 Self-checking bench for the limp home controller.
 Assumes short counts and the load model in lhc_loads.
*/
`timescale 1ns/100ps
module limp_home_controller_test;
    logic hclk = 0;
    logic hresetn = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hwrite = 0;
    logic [2:0] mode = lhc_pkg::MODE_INIT;
    lhc_pkg::lhc_evt_t evt = '0;
    lhc_pkg::lhc_pins_t pins;
    logic bl = 0;
    logic csl = 0;
    logic cfgp = 0;
    logic strap = 1;
    logic ce = 1;
    logic hsel = 1;
    logic bau = 1;
    logic [2:0] hsize = 3'h2;
    // Short counts keep the run brief; duty ratios follow the defaults
    localparam int T_INIT = 40, T_UV = 80, T_SIP = 20, T_SIL = 10;
    localparam int T_PLP = 10, T_PLL = 2;
    logic [31:0] hrdata;
    logic hrdy, hresp, em_out, em_oe, si_out, si_oe;
    logic pl_out, pl_oe, pu, fsr, swd, em_pin, si_pin, pl_pin;
    logic look = 0;
    logic [31:0] cnt = 0;
    logic [31:0] exp_q[$];
    int sel_q[$];
    int fails = 0;
    int checks = 0;
    string nm[9] = '{"hrdata", "emergency", "side", "pulsed",
        "pullup", "failsafe", "swdev", "count", "hresp"};

    // ========================================
    // Design and loads
    // Battery level for the supply timeout comes from bau
    assign pins = {bl, csl, bau, pl_pin, cfgp};
    lhc_top #(.INIT_TO_CYC(T_INIT), .UV_TO_CYC(T_UV),
        .SI_PERIOD_CYC(T_SIP), .SI_LOW_CYC(T_SIL),
        .PL_PERIOD_CYC(T_PLP), .PL_LOW_CYC(T_PLL)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
        .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .sbc_mode(mode), .evt(evt), .pins(pins),
        .emergency_out_n(em_out), .emergency_oe_n(em_oe),
        .side_indicator_out(si_out), .side_indicator_oe_n(si_oe),
        .pulsed_light_out(pl_out), .pulsed_light_oe_n(pl_oe),
        .test_pullup_en(pu), .failsafe_req(fsr), .swdev_mode(swd));
    lhc_loads u_loads (.em_out(em_out), .em_oe_n(em_oe),
        .si_out(si_out), .si_oe_n(si_oe), .pl_out(pl_out),
        .pl_oe_n(pl_oe), .strap_gnd(strap), .em_pin(em_pin),
        .si_pin(si_pin), .pl_pin(pl_pin));

    // ========================================
    // Clock, watchdog and scoreboard
    initial
    begin
        forever #50 hclk = ~hclk;
    end

    // Generous span: the whole sequence needs about 650 cycles
    initial
    begin
        repeat (6000) @(posedge hclk);
        fails++;
        finish_test;
    end

    function automatic logic [31:0] pick(int s);
        logic [31:0] v[9] = '{hrdata, em_pin, si_pin, pl_pin,
            pu, fsr, swd, cnt, hresp};
        return v[s];
    endfunction

    // Sampling on the falling edge keeps clear of output updates
    always @(negedge hclk)
    begin
        if (look)
        begin
            checks++;
            if (pick(sel_q[0]) !== exp_q[0])
            begin
                fails++;
                $display("unexpected %s: expected %0h seen %0h",
                    nm[sel_q[0]], exp_q[0], pick(sel_q[0]));
            end
            void'(sel_q.pop_front());
            void'(exp_q.pop_front());
        end
    end

    // ========================================
    // Tasks
    task automatic clk(int n);
        repeat (n) @(posedge hclk);
    endtask

    // Extra edge so look is never set and cleared in one step
    task automatic chk(int s, logic [31:0] v);
        sel_q.push_back(s);
        exp_q.push_back(v);
        look <= 1'b1;
        @(posedge hclk);
        look <= 1'b0;
        @(posedge hclk);
    endtask

    task automatic bus(logic w, logic [31:0] a, logic [31:0] d,
        logic [31:0] e);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        if (!w)
        begin
            sel_q.push_back(0);
            exp_q.push_back(e);
            look <= 1'b1;
        end
        do @(posedge hclk); while (hrdy !== 1'b1);
        look <= 1'b0;
        @(posedge hclk);
    endtask

    task automatic duty(int s, int n, int e);
        cnt = 0;
        repeat (n)
        begin
            @(negedge hclk);
            cnt += (pick(s) === 32'h0);
        end
        @(posedge hclk);
        chk(7, e);
    endtask

    task automatic wdp(logic ok);
        evt <= ok ? 5'h08 : 5'h10;
        @(posedge hclk);
        evt <= '0;
        clk(4);
    endtask

    // Restart, normal, service, then deactivate
    task automatic lift_output;
        mode <= lhc_pkg::MODE_RESTART;
        clk(3);
        mode <= lhc_pkg::MODE_NORMAL;
        clk(3);
        bus(1, lhc_pkg::ADDR_CMD, 32'h2, 0);
        clk(3);
        chk(1, 0);
        wdp(1);
        bus(1, lhc_pkg::ADDR_CMD, 32'h2, 0);
        clk(3);
        chk(1, 1);
    endtask

    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ========================================
    // Tests
    initial
    begin
        logic [7:0] cs[4] = '{8'hc0, 8'ha1, 8'h24, 8'h22};
        void'($urandom(42));
        clk(16);
        hresetn <= 1'b1;
        clk(3);
        chk(4, 1);
        chk(1, 1);
        chk(3, 0);
        mode <= lhc_pkg::MODE_NORMAL;
        clk(5);
        chk(6, 1);
        chk(4, 0);
        strap <= 1'b0;
        $display("test init done");
        bus(0, lhc_pkg::ADDR_CFG, 0, 0);
        bus(0, 32'h10 + 4 * ($urandom % 60), 0, 0);
        chk(8, 0);
        // A deselected command must be dropped
        hsel <= 1'b0;
        bus(1, lhc_pkg::ADDR_CMD, 32'h1, 0);
        hsel <= 1'b1;
        clk(3);
        chk(1, 1);
        bus(1, lhc_pkg::ADDR_CMD, ($urandom & 32'hfffffffc) | 1, 0);
        clk(3);
        chk(1, 0);
        duty(2, 20, 10);
        duty(3, 10, 2);
        // Enable low freezes the state, so init cannot force it off
        ce <= 1'b0;
        mode <= lhc_pkg::MODE_INIT;
        clk(3);
        chk(1, 0);
        ce <= 1'b1;
        mode <= lhc_pkg::MODE_SLEEP;
        clk(3);
        chk(1, 0);
        mode <= lhc_pkg::MODE_NORMAL;
        bus(1, lhc_pkg::ADDR_CMD, 32'h2, 0);
        clk(3);
        chk(1, 1);
        chk(2, 1);
        mode <= lhc_pkg::MODE_STOP;
        bus(1, lhc_pkg::ADDR_CMD, 32'h1, 0);
        clk(3);
        chk(1, 1);
        mode <= lhc_pkg::MODE_NORMAL;
        bl <= 1'b1;
        clk(2);
        bus(1, lhc_pkg::ADDR_CMD, 32'h1, 0);
        clk(5);
        chk(1, 1);
        bl <= 1'b0;
        $display("test serial done");
        wdp(0);
        chk(1, 1);
        wdp(0);
        chk(1, 0);
        lift_output;
        bus(1, lhc_pkg::ADDR_CFG, 32'h1, 0);
        bus(0, lhc_pkg::ADDR_CFG, 0, 1);
        wdp(0);
        chk(1, 0);
        lift_output;
        bus(1, lhc_pkg::ADDR_CFG, 32'h0, 0);
        $display("test watchdog done");
        // Mode in the top three bits, fault levels below
        foreach (cs[i])
        begin
            mode <= cs[i][7:5];
            evt <= cs[i][4:0];
            clk(4);
            chk(1, 0);
            evt <= '0;
            lift_output;
        end
        $display("test causes done");
        // Battery below its threshold: no timeout however long
        bau <= 1'b0;
        csl <= 1'b1;
        clk(90);
        chk(5, 0);
        bau <= 1'b1;
        clk(60);
        chk(5, 0);
        clk(30);
        chk(5, 1);
        chk(1, 0);
        csl <= 1'b0;
        clk(4);
        lift_output;
        $display("test undervoltage done");
        hresetn <= 1'b0;
        mode <= lhc_pkg::MODE_INIT;
        clk(16);
        hresetn <= 1'b1;
        clk(50);
        chk(1, 0);
        mode <= lhc_pkg::MODE_NORMAL;
        clk(4);
        chk(6, 0);
        $display("test timeout done");
        finish_test;
    end
endmodule
